// ### rtl/graphics_status_defines.svh
/*
 Offsets, field positions, reset values and figures of the status block.
 Assumes inclusion by bare name from the modules; the package does not include it.
*/
`ifndef GRAPHICS_STATUS_DEFINES_SVH
`define GRAPHICS_STATUS_DEFINES_SVH

`define STATUS_ADDR_W        4
`define STATUS_OFFSET        4'h0
`define CONTROL_OFFSET       4'h4
`define REG_RESET            32'h00000000
`define STATUS_TPX_LSB       0
`define STATUS_TPY1_BIT      4
`define STATUS_BLEND_LSB     5
`define STATUS_DEPTH_LSB     7
`define STATUS_DITHER_BIT    9
`define STATUS_DRAWDISP_BIT  10
`define STATUS_SETMASK_BIT   11
`define STATUS_SKIPMASK_BIT  12
`define STATUS_FIELD_BIT     13
`define STATUS_FLIP_BIT      14
`define STATUS_TPY2_BIT      15
`define STATUS_HRES2_BIT     16
`define STATUS_HRES1_LSB     17
`define STATUS_VRES_BIT      19
`define STATUS_VMODE_BIT     20
`define STATUS_CDEPTH_BIT    21
`define STATUS_INTERLACE_BIT 22
`define STATUS_DISPOFF_BIT   23
`define STATUS_IRQ_BIT       24
`define STATUS_DREQ_BIT      25
`define STATUS_CMDRDY_BIT    26
`define STATUS_RDRDY_BIT     27
`define STATUS_BLKRDY_BIT    28
`define STATUS_DIR_LSB       29
`define STATUS_ODD_BIT       31
`define DIR_OFF              2'h0
`define DIR_FIFO             2'h1
`define DIR_TO_CMD           2'h2
`define DIR_FROM_READ        2'h3
`define DISPLAY_OFF_RESET    1'b1

`endif

// ### rtl/graphics_status_pkg.sv
/*
 Types of the graphics status word block.
 Assumes the defines header is on the include path.
*/
package graphics_status_pkg;

    // Drawing-mode settings from the texture page and mask commands
    typedef struct packed {
        logic       tex_y2;
        logic       skip_masked;
        logic       set_mask;
        logic       draw_to_display;
        logic       dither;
        logic [1:0] tex_depth;
        logic [1:0] blend;
        logic       tex_y1;
        logic [3:0] tex_x;
    } draw_mode_t;

    // Display-mode settings from the display control port
    typedef struct packed {
        logic       display_off;
        logic [1:0] direction;
        logic       flip;
        logic       hres2;
        logic       interlace;
        logic       color24;
        logic       pal;
        logic       vres480;
        logic [1:0] hres1;
    } disp_mode_t;

    // Live flags from the command front end and video timing
    typedef struct packed {
        logic fifo_not_full;
        logic cmd_ready;
        logic read_ready;
        logic block_ready;
        logic field;
        logic odd_line;
        logic vblank;
    } live_flags_t;

    typedef enum logic [1:0] {
        ACK_IDLE,
        ACK_SEEN
    } irq_state_t;

endpackage

// ### rtl/irq_flag.sv
/*
 Pending graphics interrupt flag: set by the request command, cleared by
 the acknowledge command. Assumes both strobes come from mclk logic.
*/
`timescale 1ns/1ps
module irq_flag (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic set_pulse,
    input  wire logic clear_pulse,
    output logic      pending
);
    logic next_pending;

    always_comb begin
        next_pending = pending;
        if (clear_pulse) begin
            next_pending = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (set_pulse) begin
            next_pending = 1'b1; // [R13]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pending <= 1'b0;
        end else begin
            pending <= next_pending;
        end
    end
endmodule

// ### rtl/pin_sync.sv
/*
 Three-stage synchroniser for a level from another domain. The output
 changes only once the second and third stages agree.
*/
`timescale 1ns/1ps
module pin_sync (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level
);
    logic       stage1;
    logic       stage2;
    logic       stage3;
    logic       next_level;

    always_comb begin
        next_level = level;
        if (stage2 == stage3) begin
            next_level = stage3;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
        end
    end
endmodule

// ### rtl/graphics_status.sv
/*
 Read-only graphics status word with its setting latches.
 Assumes settings, strobes and live flags arrive on mclk, except the
 video blanking and odd-line levels, which arrive from the video clock.
 A plain register port gives the status word and a revision control.
*/
`timescale 1ns/1ps
`include "graphics_status_defines.svh"

// Contract
// R1: Bits 0-3 give texture page X base, units of 64.
// R2: Bits 5-6 give the semi-transparency blend mode.
// R3: Bits 7-8 give texture colour depth; 3 reserved.
// R4: Bit 9 shows dithering on or off.
// R5: Bit 10 shows drawing to displayed area allowed.
// R6: Bit 11 set-mask on draw; bit 12 skip masked pixels.
// R7: Bit 13 interlace field; later revision reads 1 without interlace.
// R8: Bit 14 horizontal flip; bit 15 second texture Y base bit.
// R9: Bit 16 selects 368 width; bits 17-18 other widths.
// R10: Bit 19 vertical resolution, 480 only meaningful with interlace.
// R11: Bit 20 video standard; bit 21 display colour depth.
// R12: Bit 22 vertical interlace; bit 23 display disabled when set.
// R13: Bit 24 interrupt pending: request command sets, acknowledge clears.
// R14: Bit 25 request depends on direction: 0, not-full, bit28, bit27.
// R15: Bit 26 set when ready for a new command word.
// R16: Bit 27 set from readback command until all data read.
// R17: Bit 28 clears when busy; early for polygon and line.
// R18: DMA uses bit 28 and 27 as requests; no split primitives.
// R19: Bits 29-30 give the transfer direction.
// R20: Bit 31 odd-line indicator, per frame or per scanline.
// R21: Bit 31 reads zero through all vertical blanking.
// R22: Reads have no side effects; writes never change status bits. A write of the control revision can force bit 13 high.
module graphics_status (
    input  wire logic                             mclk,
    input  wire logic                             rstn,
    input  wire logic [`STATUS_ADDR_W-1:0]        addr,
    input  wire logic [31:0]                      wdata,
    input  wire logic                             wr,
    input  wire logic                             rd,
    output logic      [31:0]                      rdata,
    input  wire logic                             draw_mode_load,
    input  wire graphics_status_pkg::draw_mode_t  draw_mode_in,
    input  wire logic                             disp_mode_load,
    input  wire graphics_status_pkg::disp_mode_t  disp_mode_in,
    input  wire logic                             irq_request,
    input  wire logic                             irq_ack,
    input  wire graphics_status_pkg::live_flags_t live_in,
    input  wire logic                             vblank_pin,
    input  wire logic                             odd_pin,
    output logic                                  graphics_interrupt_line,
    output logic [31:0]                           status_word
);
    graphics_status_pkg::draw_mode_t draw_mode;
    graphics_status_pkg::draw_mode_t next_draw_mode;
    graphics_status_pkg::disp_mode_t disp_mode;
    graphics_status_pkg::disp_mode_t next_disp_mode;
    logic                            later_rev;
    logic                            next_later_rev;
    logic [31:0]                     next_rdata;
    logic [31:0]                     word;
    logic                            irq_pending;
    logic                            vblank;
    logic                            odd_sync;
    logic                            dreq;
    logic                            field_bit;

    irq_flag u_irq (
        .mclk        (mclk),
        .rstn        (rstn),
        .set_pulse   (irq_request),
        .clear_pulse (irq_ack),
        .pending     (irq_pending)
    );

    pin_sync u_vblank (
        .mclk  (mclk),
        .rstn  (rstn),
        .pin   (vblank_pin),
        .level (vblank)
    );

    pin_sync u_odd (
        .mclk  (mclk),
        .rstn  (rstn),
        .pin   (odd_pin),
        .level (odd_sync)
    );

    // Setting latches, loaded only by their commands
    always_comb begin
        next_draw_mode = draw_mode;
        next_disp_mode = disp_mode;
        if (draw_mode_load) begin
            next_draw_mode = draw_mode_in; // [R1] [R2] [R3] [R4] [R5] [R6]
        end
        if (disp_mode_load) begin
            next_disp_mode = disp_mode_in; // [R9] [R11] [R12] [R19]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            draw_mode <= '0;
            disp_mode <= '0;
            disp_mode.display_off <= `DISPLAY_OFF_RESET;
        end else begin
            draw_mode <= next_draw_mode;
            disp_mode <= next_disp_mode;
        end
    end

    // Request bit selection by transfer direction
    always_comb begin
        case (disp_mode.direction)
            `DIR_OFF:       dreq = 1'b0; // [R14]
            `DIR_FIFO:      dreq = live_in.fifo_not_full;
            `DIR_TO_CMD:    dreq = live_in.block_ready; // [R18]
            `DIR_FROM_READ: dreq = live_in.read_ready;
            default:        dreq = 1'b0;
        endcase
    end

    // Later revision forces the field bit high without interlace
    always_comb begin
        field_bit = live_in.field;
        if (later_rev && !disp_mode.interlace) begin
            field_bit = 1'b1; // [R7]
        end
    end

    always_comb begin
        word = `REG_RESET;
        word[`STATUS_TPX_LSB +: 4]    = draw_mode.tex_x; // [R1]
        word[`STATUS_TPY1_BIT]        = draw_mode.tex_y1;
        word[`STATUS_BLEND_LSB +: 2]  = draw_mode.blend; // [R2]
        word[`STATUS_DEPTH_LSB +: 2]  = draw_mode.tex_depth; // [R3]
        word[`STATUS_DITHER_BIT]      = draw_mode.dither; // [R4]
        word[`STATUS_DRAWDISP_BIT]    = draw_mode.draw_to_display; // [R5]
        word[`STATUS_SETMASK_BIT]     = draw_mode.set_mask; // [R6]
        word[`STATUS_SKIPMASK_BIT]    = draw_mode.skip_masked; // [R6]
        word[`STATUS_FIELD_BIT]       = field_bit; // [R7]
        word[`STATUS_FLIP_BIT]        = disp_mode.flip; // [R8]
        word[`STATUS_TPY2_BIT]        = draw_mode.tex_y2; // [R8]
        word[`STATUS_HRES2_BIT]       = disp_mode.hres2; // [R9]
        word[`STATUS_HRES1_LSB +: 2]  = disp_mode.hres1; // [R9]
        word[`STATUS_VRES_BIT]        = disp_mode.vres480; // [R10]
        word[`STATUS_VMODE_BIT]       = disp_mode.pal; // [R11]
        word[`STATUS_CDEPTH_BIT]      = disp_mode.color24; // [R11]
        word[`STATUS_INTERLACE_BIT]   = disp_mode.interlace; // [R12]
        word[`STATUS_DISPOFF_BIT]     = disp_mode.display_off; // [R12]
        word[`STATUS_IRQ_BIT]         = irq_pending; // [R13]
        word[`STATUS_DREQ_BIT]        = dreq; // [R14]
        word[`STATUS_CMDRDY_BIT]      = live_in.cmd_ready; // [R15]
        word[`STATUS_RDRDY_BIT]       = live_in.read_ready; // [R16]
        word[`STATUS_BLKRDY_BIT]      = live_in.block_ready; // [R17]
        word[`STATUS_DIR_LSB +: 2]    = disp_mode.direction; // [R19]
        word[`STATUS_ODD_BIT]         = odd_sync & ~vblank; // [R20] [R21]
    end

    // Register port: status is read-only, control holds the revision
    always_comb begin
        next_later_rev = later_rev;
        next_rdata     = `REG_RESET;
        if (wr && addr == `CONTROL_OFFSET) begin
            next_later_rev = wdata[0];
        end
        if (rd) begin
            case (addr)
                `STATUS_OFFSET:  next_rdata = word; // [R22]
                `CONTROL_OFFSET: next_rdata = {31'h00000000, later_rev};
                default:         next_rdata = `REG_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            later_rev               <= 1'b0;
            rdata                   <= `REG_RESET;
            status_word             <= `REG_RESET;
            graphics_interrupt_line <= 1'b0;
        end else begin
            later_rev               <= next_later_rev;
            rdata                   <= next_rdata;
            status_word             <= word;
            graphics_interrupt_line <= irq_pending;
        end
    end
endmodule

// ### testbench/dma_request_model.sv
/*
 Host DMA side: raises its block request from the status word.
 Assumes the status word of the block and the same mclk.
*/
`timescale 1ns/1ps
module dma_request_model (
    input  wire logic        mclk,
    input  wire logic [31:0] status_word,
    output logic             dma_req
);
    // Bit 28 paces commands, bit 27 paces readback
    always_ff @(posedge mclk) begin
        dma_req <= status_word[30] &
            (status_word[29] ? status_word[27] : status_word[28]);
    end
endmodule

// ### testbench/graphics_status_chk.sv
/*
 Port assertions of the status block.
 Assumes binding into every graphics_status instance.
*/
`timescale 1ns/1ps
`include "graphics_status_defines.svh"
module graphics_status_chk (
    input wire logic                             mclk,
    input wire logic                             rstn,
    input wire logic [`STATUS_ADDR_W-1:0]        addr,
    input wire logic                             rd,
    input wire logic [31:0]                      rdata,
    input wire logic                             draw_mode_load,
    input wire graphics_status_pkg::draw_mode_t  draw_mode_in,
    input wire logic                             disp_mode_load,
    input wire graphics_status_pkg::disp_mode_t  disp_mode_in,
    input wire logic                             irq_request,
    input wire logic                             irq_ack,
    input wire graphics_status_pkg::live_flags_t live_in,
    input wire logic                             graphics_interrupt_line,
    input wire logic [31:0]                      status_word
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [1:0] dir;
    assign dir = status_word[30:29];
    sequence s_irq_up;
        ##2 (graphics_interrupt_line && status_word[24]);
    endsequence
    sequence s_irq_dn;
        ##2 !(graphics_interrupt_line || status_word[24]);
    endsequence
    property p_draw;
        draw_mode_load |-> ##2
            {status_word[15], status_word[12:0]} == $past(draw_mode_in, 2);
    endproperty
    property p_disp;
        disp_mode_load |-> ##2 {status_word[23], dir, status_word[14],
            status_word[16], status_word[22:17]} == $past(disp_mode_in, 2);
    endproperty
    property p_live;
        $past(rstn) |-> status_word[28:26] == {$past(live_in.block_ready),
            $past(live_in.read_ready), $past(live_in.cmd_ready)};
    endproperty
    property p_dir_low;
        $past(rstn) && !dir[1] |->
            status_word[25] == (dir[0] & $past(live_in.fifo_not_full));
    endproperty
    property p_dir_high;
        dir[1] |-> status_word[25] ==
            (dir[0] ? status_word[27] : status_word[28]);
    endproperty
    property p_rd;
        rd && addr == `STATUS_OFFSET |=> rdata == status_word;
    endproperty
    property p_idle;
        !rd |=> rdata == 32'h0;
    endproperty
    property p_irq_set;
        irq_request |-> s_irq_up;
    endproperty
    property p_irq_clr;
        irq_ack && !irq_request |-> s_irq_dn;
    endproperty
    a_draw: assert property (p_draw) else $error("draw mode");
    a_disp: assert property (p_disp) else $error("display mode");
    a_live: assert property (p_live) else $error("ready flags");
    a_dir_low: assert property (p_dir_low) else $error("request");
    a_dir_high: assert property (p_dir_high) else $error("mirror");
    a_rd: assert property (p_rd) else $error("read data");
    a_idle: assert property (p_idle) else $error("idle read data");
    a_irq_set: assert property (p_irq_set) else $error("irq set");
    a_irq_clr: assert property (p_irq_clr) else $error("irq clear");
endmodule
bind graphics_status graphics_status_chk graphics_status_chk_inst (.*);

// ### testbench/graphics_status_test.sv
/*
 Self-checking bench of the status block with random settings.
 Assumes the block, its checker and the DMA request model.
*/
`timescale 1ns/1ps
`include "graphics_status_defines.svh"
module graphics_status_test;
    logic        mclk = 0, rstn = 0, wr = 0, rd = 0, rev = 0, irq = 0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, status_word, got, ew;
    logic        draw_mode_load = 0, disp_mode_load = 0;
    logic        irq_request = 0, irq_ack = 0, vblank_pin = 1, odd_pin = 1;
    logic        graphics_interrupt_line, dma_req;
    logic [15:0] lfsr = 16'h6, r, r2, r3;
    int          error_cnt = 0, tests_run = 0;
    graphics_status_pkg::draw_mode_t  draw_mode_in = '0;
    graphics_status_pkg::disp_mode_t  disp_mode_in = 11'h400;
    graphics_status_pkg::live_flags_t live_in = '0;
    graphics_status graphics_status_inst (.*);
    dma_request_model dma_request_model_inst (.mclk(mclk),
        .status_word(status_word), .dma_req(dma_req));
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [31:0] exp_word();
        logic [31:0] w;
        logic [1:0]  d;
        d = disp_mode_in.direction;
        w = {odd_pin & ~vblank_pin, d, live_in.block_ready,
            live_in.read_ready, live_in.cmd_ready, 1'b0, irq,
            disp_mode_in[10], disp_mode_in[5:0], disp_mode_in.hres2,
            draw_mode_in.tex_y2, disp_mode_in.flip,
            live_in.field | (rev & ~disp_mode_in.interlace),
            draw_mode_in[12:0]};
        w[25] = d[1] ? (d[0] ? w[27] : w[28]) : d[0] & live_in[6];
        return w;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        @(posedge mclk);
        wr <= 0;
        rd <= 0;
        #1 got = rdata;
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1;
        bus(0, `STATUS_OFFSET, 0);
        chk(got, exp_word());
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            r2 = rnd();
            r3 = rnd();
            @(posedge mclk);
            draw_mode_in <= r[13:0];
            disp_mode_in <= {r2[10], i[1:0], r2[7:0]};
            live_in <= r3[6:0] & ~{4'h0, ~r2[5], 2'h0};
            {draw_mode_load, disp_mode_load} <= 2'h3;
            {irq_request, irq_ack} <= r3[8:7];
            @(posedge mclk);
            {draw_mode_load, disp_mode_load, irq_request, irq_ack} <= 4'h0;
            irq = r3[8] | (irq & ~r3[7]);
            bus(1, `STATUS_OFFSET, {r3, r});
            bus(0, `STATUS_OFFSET, 0);
            ew = exp_word();
            chk(got[15:0], ew[15:0]);
            chk(got[31:16], ew[31:16]);
            chk(graphics_interrupt_line, irq);
            chk(dma_req, ew[30] & ew[25]);
        end
        bus(0, 4'h8, 0);
        chk(got, 32'h0);
        bus(1, `CONTROL_OFFSET, 32'h1);
        rev = 1;
        @(posedge mclk);
        disp_mode_in <= disp_mode_in & ~11'h20;
        disp_mode_load <= 1;
        @(posedge mclk);
        disp_mode_load <= 0;
        vblank_pin <= 0;
        repeat (8) @(posedge mclk);
        bus(0, `STATUS_OFFSET, 0);
        chk(got, exp_word());
        vblank_pin <= 1;
        repeat (8) @(posedge mclk);
        bus(0, `STATUS_OFFSET, 0);
        chk(got, exp_word());
        stop_test();
    end
endmodule
